// File: hw/tcs_regs.vh
`ifndef TCS_REGS_VH
`define TCS_REGS_VH
// Register indices; byte address is four times the index
`define TCS_IDX_CTRL 8'h12
`define TCS_IDX_STAT 8'h13
`define TCS_IDX_CAP1H 8'h14
`define TCS_IDX_CAP1L 8'h15
`define TCS_IDX_CMP1H 8'h16
`define TCS_IDX_CMP1L 8'h17
`define TCS_IDX_CNTH 8'h18
`define TCS_IDX_CNTL 8'h19
`define TCS_IDX_ALTH 8'h1A
`define TCS_IDX_ALTL 8'h1B
`define TCS_IDX_CAP2H 8'h1C
`define TCS_IDX_CAP2L 8'h1D
`define TCS_IDX_CMP2H 8'h1E
`define TCS_IDX_CMP2L 8'h1F
// Control register fields
`define TCS_CTL_CAP_IE 7
`define TCS_CTL_CMP_IE 6
`define TCS_CTL_OVF_IE 5
`define TCS_CTL_FORCE2 4
`define TCS_CTL_FORCE1 3
`define TCS_CTL_LVL2 2
`define TCS_CTL_EDGE1 1
`define TCS_CTL_LVL1 0
// Status register fields
`define TCS_ST_CAP1 7
`define TCS_ST_CMP1 6
`define TCS_ST_OVF 5
`define TCS_ST_CAP2 4
`define TCS_ST_CMP2 3
// Reset values and timing
`define TCS_CNT_RESET 16'hFFFC
`define TCS_PRESCALE_MAX 2'h3
`endif

// File: hw/tcs_timer.v
`include "tcs_regs.vh"
`default_nettype none
// Overview of the register view
// Every register is one byte wide and sits in the low byte of its word.
// The byte address of a register is four times its index.
// Upper bits of every read word are zero.
// Unmapped or misaligned accesses raise the error response.
// A refused access decodes paddr[9:2] alone: a misaligned or aliased one reaches that register; others write nothing and read zero.
// The slave never inserts wait states.
// Read data is loaded on the setup edge and stands until the next read.
//
// Control register
// Bit 7 enables the interrupt for both capture flags.
// Bit 6 enables the interrupt for both compare flags.
// Bit 5 enables the interrupt for the overflow flag.
// Bits 4 and 3 are force strobes; they are never stored and read zero.
// Bit 2 is the level for compare output two.
// Bit 1 selects the capture one edge: one is rising, zero is falling.
// Bit 0 is the level for compare output one.
// A force strobe takes the level from the same write, not the old one.
// That way one write can both set a new level and drive it out.
//
// Status register
// Bits 7 to 3 hold capture one, compare one, overflow, capture two and
// compare two; bits 2 to 0 read zero.
// Status is read only; writes to it are ignored.
//
// Flag clearing
// A status read arms only the flags that are set at that moment.
// The matching access then clears an armed flag.
// Capture flags clear on a read of their low byte.
// Compare flags clear on a read or a write of their low byte.
// Overflow clears on a read of the main counter low byte only.
// The alternate counter never clears overflow, so software that times
// intervals should use it when overflow interrupts matter.
// A flag event in the cycle of the clearing access keeps the flag set.
// Limitation: an arm is dropped by the matching access even if the flag
// was set again in between, so a fresh event needs a fresh status read.
//
// Counter
// The counter leaves reset four counts short of the wrap.
// It steps once every four clocks through a two-bit prescaler.
// Overflow is flagged on the step from all ones to zero.
// A write to either low counter byte reloads the reset value and the
// prescaler and ends any pending high-then-low read sequence.
// Reading a high counter byte freezes the low byte in a buffer until a
// low byte read; the buffer loads one clock after the high byte is sampled, so a carry at that step splits the pair.
//
// Compare channels
// Each compare is judged once per count, on the first clock of the count.
// Judging once keeps a match from firing four times per count.
// A write to a high byte inhibits the compare until the low byte write.
// A write to a low byte alone does not inhibit anything.
// The output latch takes the level bit on the same edge that sets the compare flag.
// The output latch is updated whether or not the flag was already set.
//
// Capture channels
// Each pin passes two flops before any logic reads it.
// An edge is therefore seen about three clocks after the pin moves.
// The stored value is one count ahead of the counter at detection.
// Capture one follows the edge select; capture two is falling only.
// Reading capture one high blocks new transfers until its low byte read.
// The flag is still set by a blocked edge, so software can see a miss.
// Capture and compare data registers hold no reset value.
// In simulation they read unknown until written or captured.
//
// Interrupt
// One level output, high while any enabled flag stands.
// It is combinational so it tracks flag and enable changes at once.
// Clearing an enable drops the request without touching the flag.
//
// Reset
// Reset is asynchronous and active low.
// Control, flags, arms, locks and output latches clear on reset.
// The counter loads its reset value and the prescaler clears.
// Low-power stop handling is not part of this block.
module tcs_timer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire capture_one_pin,
  input wire capture_two_pin,
  output wire compare_one_pin,
  output wire compare_two_pin,
  output wire timer_irq
);
  wire [7:0] idx = paddr[9:2];
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
             (idx >= `TCS_IDX_CTRL) && (idx <= `TCS_IDX_CMP2L);
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;

  reg [7:0] ctrl_r;
  reg [4:0] flag_r;
  reg [4:0] armed_r;
  reg [15:0] cnt_r;
  reg [1:0] pre_r;
  reg [7:0] cnt_buf_r;
  reg cnt_hold_r;
  reg [15:0] cap1_r;
  reg [15:0] cap2_r;
  reg cap1_lock_r;
  reg [15:0] cmp1_r;
  reg [15:0] cmp2_r;
  reg cmp1_inh_r;
  reg cmp2_inh_r;
  reg lvl1_r;
  reg lvl2_r;
  reg [2:0] c1_sync_r;
  reg [2:0] c2_sync_r;

  // Pins pass two flops; the third stage only feeds edge detection
  // Reset low: rising-only edges appear while the pins settle, and no
  // enabled trigger is rising after reset, so no false capture follows it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_sync_r <= 3'h0;
      c2_sync_r <= 3'h0;
    end else begin
      c1_sync_r <= {c1_sync_r[1:0], capture_one_pin};
      c2_sync_r <= {c2_sync_r[1:0], capture_two_pin};
    end
  end

  wire c1_rise = c1_sync_r[1] & ~c1_sync_r[2];
  wire c1_fall = ~c1_sync_r[1] & c1_sync_r[2];
  wire cap1_evt = ctrl_r[`TCS_CTL_EDGE1] ? c1_rise : c1_fall;
  wire cap2_evt = ~c2_sync_r[1] & c2_sync_r[2];

  // Counter step and wrap
  wire tick = (pre_r == `TCS_PRESCALE_MAX);
  wire wrap = tick & (cnt_r == 16'hFFFF);
  wire cnt_reload = wr & ((idx == `TCS_IDX_CNTL) || (idx == `TCS_IDX_ALTL));
  // Compare is judged once per counter step, on the first clock of the new count
  wire step0 = (pre_r == 2'h0);
  wire cmp1_evt = step0 & ~cmp1_inh_r & (cmp1_r == cnt_r);
  wire cmp2_evt = step0 & ~cmp2_inh_r & (cmp2_r == cnt_r);

  // Free-running counter with divide-by-four prescaler
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= `TCS_CNT_RESET;
      pre_r <= 2'h0;
    end else if (cnt_reload) begin
      cnt_r <= `TCS_CNT_RESET;
      pre_r <= 2'h0;
    end else begin
      pre_r <= pre_r + 2'h1;
      if (tick)
        cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Counter high read freezes low byte until low byte read or reload
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_hold_r <= 1'b0;
      cnt_buf_r <= 8'h00;
    end else if (cnt_reload) begin
      cnt_hold_r <= 1'b0;
    end else if (rd && (idx == `TCS_IDX_CNTH || idx == `TCS_IDX_ALTH)) begin
      if (!cnt_hold_r)
        cnt_buf_r <= cnt_r[7:0];
      cnt_hold_r <= 1'b1;
    end else if (rd && (idx == `TCS_IDX_CNTL || idx == `TCS_IDX_ALTL)) begin
      cnt_hold_r <= 1'b0;
    end
  end

  // Capture registers carry no reset, so contents survive it
  always @(posedge pclk) begin
    // The stored value is one count ahead of the counter at detection
    if (cap1_evt && !cap1_lock_r)
      cap1_r <= cnt_r + 16'h0001;
    if (cap2_evt)
      cap2_r <= cnt_r + 16'h0001;
    if (wr && idx == `TCS_IDX_CMP1H)
      cmp1_r[15:8] <= pwdata[7:0];
    if (wr && idx == `TCS_IDX_CMP1L)
      cmp1_r[7:0] <= pwdata[7:0];
    if (wr && idx == `TCS_IDX_CMP2H)
      cmp2_r[15:8] <= pwdata[7:0];
    if (wr && idx == `TCS_IDX_CMP2L)
      cmp2_r[7:0] <= pwdata[7:0];
  end

  // Capture lock and compare inhibit sequencing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap1_lock_r <= 1'b0;
      cmp1_inh_r <= 1'b0;
      cmp2_inh_r <= 1'b0;
    end else begin
      // Low read alone only releases; it never sets the lock
      if (rd && idx == `TCS_IDX_CAP1H)
        cap1_lock_r <= 1'b1;
      else if (rd && idx == `TCS_IDX_CAP1L)
        cap1_lock_r <= 1'b0;
      if (wr && idx == `TCS_IDX_CMP1H)
        cmp1_inh_r <= 1'b1;
      else if (wr && idx == `TCS_IDX_CMP1L)
        cmp1_inh_r <= 1'b0;
      if (wr && idx == `TCS_IDX_CMP2H)
        cmp2_inh_r <= 1'b1;
      else if (wr && idx == `TCS_IDX_CMP2L)
        cmp2_inh_r <= 1'b0;
    end
  end

  // Control register; force bits are strobes and never stored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_r <= 8'h00;
    else if (wr && idx == `TCS_IDX_CTRL)
      ctrl_r <= pwdata[7:0] & 8'hE7;
  end

  wire force1 = wr & (idx == `TCS_IDX_CTRL) & pwdata[`TCS_CTL_FORCE1];
  wire force2 = wr & (idx == `TCS_IDX_CTRL) & pwdata[`TCS_CTL_FORCE2];

  // Output level latches; force writes the fresh level bit, flags untouched
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl1_r <= 1'b0;
      lvl2_r <= 1'b0;
    end else begin
      if (force1)
        lvl1_r <= pwdata[`TCS_CTL_LVL1];
      else if (cmp1_evt)
        lvl1_r <= ctrl_r[`TCS_CTL_LVL1];
      if (force2)
        lvl2_r <= pwdata[`TCS_CTL_LVL2];
      else if (cmp2_evt)
        lvl2_r <= ctrl_r[`TCS_CTL_LVL2];
    end
  end

  assign compare_one_pin = lvl1_r;
  assign compare_two_pin = lvl2_r;

  // Flag clear: status read arms the flags then set; matching access clears
  wire st_rd = rd & (idx == `TCS_IDX_STAT);
  wire [4:0] flag_set;
  wire [4:0] flag_acc;
  assign flag_set[4] = cap1_evt;
  assign flag_set[3] = cmp1_evt;
  assign flag_set[2] = wrap;
  assign flag_set[1] = cap2_evt;
  assign flag_set[0] = cmp2_evt;
  assign flag_acc[4] = rd & (idx == `TCS_IDX_CAP1L);
  assign flag_acc[3] = acc & (idx == `TCS_IDX_CMP1L);
  assign flag_acc[2] = rd & (idx == `TCS_IDX_CNTL);
  assign flag_acc[1] = rd & (idx == `TCS_IDX_CAP2L);
  assign flag_acc[0] = acc & (idx == `TCS_IDX_CMP2L);

  // Set wins over clear so an event at the clearing access is kept
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_flag
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_r[g] <= 1'b0;
          armed_r[g] <= 1'b0;
        end else begin
          if (flag_set[g])
            flag_r[g] <= 1'b1;
          else if (armed_r[g] && flag_acc[g])
            flag_r[g] <= 1'b0;
          if (st_rd)
            armed_r[g] <= flag_r[g];
          else if (flag_acc[g])
            armed_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // One interrupt line, level while any enabled flag stands
  assign timer_irq = (ctrl_r[`TCS_CTL_CAP_IE] & (flag_r[4] | flag_r[1])) |
                     (ctrl_r[`TCS_CTL_CMP_IE] & (flag_r[3] | flag_r[0])) |
                     (ctrl_r[`TCS_CTL_OVF_IE] & flag_r[2]);

  // Read mux; indices outside the map read zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite) begin
      if (idx == `TCS_IDX_CTRL)
        prdata <= {24'h000000, ctrl_r};
      else if (idx == `TCS_IDX_STAT)
        prdata <= {24'h000000, flag_r, 3'h0};
      else if (idx == `TCS_IDX_CAP1H)
        prdata <= {24'h000000, cap1_r[15:8]};
      else if (idx == `TCS_IDX_CAP1L)
        prdata <= {24'h000000, cap1_r[7:0]};
      else if (idx == `TCS_IDX_CMP1H)
        prdata <= {24'h000000, cmp1_r[15:8]};
      else if (idx == `TCS_IDX_CMP1L)
        prdata <= {24'h000000, cmp1_r[7:0]};
      else if (idx == `TCS_IDX_CNTH || idx == `TCS_IDX_ALTH)
        prdata <= {24'h000000, cnt_r[15:8]};
      else if (idx == `TCS_IDX_CNTL || idx == `TCS_IDX_ALTL)
        prdata <= {24'h000000, cnt_hold_r ? cnt_buf_r : cnt_r[7:0]};
      else if (idx == `TCS_IDX_CAP2H)
        prdata <= {24'h000000, cap2_r[15:8]};
      else if (idx == `TCS_IDX_CAP2L)
        prdata <= {24'h000000, cap2_r[7:0]};
      else if (idx == `TCS_IDX_CMP2H)
        prdata <= {24'h000000, cmp2_r[15:8]};
      else if (idx == `TCS_IDX_CMP2L)
        prdata <= {24'h000000, cmp2_r[7:0]};
      else
        prdata <= 32'h00000000;
    end
  end
endmodule // tcs_timer
`default_nettype wire

// File: bench/tcs_pins.sv
`default_nettype none
// Capture pins as driven from outside the device
module tcs_pins (
  input wire logic pclk,
  output logic cap_one,
  output logic cap_two
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line two idles high so its first move is a falling edge
  initial begin
    cap_one = 1'b0;
    cap_two = 1'b1;
  end
  // Pins move just after an edge; the device syncs them itself
  task automatic drive(input logic ch, input logic lv);
    @(posedge pclk);
    if (ch) cap_two <= lv;
    else cap_one <= lv;
  endtask
endmodule // tcs_pins
`default_nettype wire

// File: bench/tcs_timer_properties.sv
`default_nettype none
module tcs_timer_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic compare_one_pin,
  input wire logic compare_two_pin,
  input wire logic timer_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctrl_r;
  wire acc = psel && penable;
  wire wr_ctrl = acc && pwrite && paddr == 12'h048;
  wire rd_stat = acc && !pwrite && paddr == 12'h04C;
  // Shadow of the bits that stand; force bits never stick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_r <= 8'h00;
    else if (wr_ctrl) ctrl_r <= pwdata[7:0] & 8'hE7;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  force_one_a: assert property (wr_ctrl && pwdata[3] |=> ##[0:1] compare_one_pin == ctrl_r[0])
    else $error("force one bad");
  force_two_a: assert property (wr_ctrl && pwdata[4] |=> ##[0:1] compare_two_pin == ctrl_r[2])
    else $error("force two bad");
  ctrl_read_a: assert property (acc && !pwrite && paddr == 12'h048 |-> prdata == {24'h0, ctrl_r})
    else $error("control read bad");
  status_pad_a: assert property (rd_stat |-> prdata[31:8] == 24'h0 && prdata[2:0] == 3'h0)
    else $error("status pad bad");
  irq_cap_a: assert property (rd_stat && prdata[7] && ctrl_r[7] |-> timer_irq)
    else $error("capture irq missing");
  irq_cmp_a: assert property (rd_stat && (prdata[6] || prdata[3]) && ctrl_r[6] |-> timer_irq)
    else $error("compare irq missing");
  irq_ovf_a: assert property (rd_stat && prdata[5] && ctrl_r[5] |-> timer_irq)
    else $error("overflow irq missing");
  irq_off_a: assert property (wr_ctrl && pwdata[7:5] == 3'h0 |=> !timer_irq)
    else $error("irq while disabled");
  irq_fall_a: assert property ($fell(timer_irq) |-> $past(acc))
    else $error("irq fell untouched");
endmodule // tcs_timer_properties
`default_nettype wire

// File: bench/tcs_timer_bench.sv
`include "tcs_regs.vh"
`default_nettype none
module tcs_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, cap_one, cap_two, cmp_one, cmp_two, irq;
  logic [15:0] c0, c1, v;
  int err_total = 0, compares = 0;
  always #12.5 pclk = ~pclk;
  tcs_pins tcs_pins_inst (.pclk(pclk), .cap_one(cap_one), .cap_two(cap_two));
  tcs_timer tcs_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_one_pin(cap_one), .capture_two_pin(cap_two),
    .compare_one_pin(cmp_one), .compare_two_pin(cmp_two), .timer_irq(irq));
  // One APB transfer; settles to the falling edge so outputs are stable
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic st();
    apb(1'b0, `TCS_IDX_STAT, 8'h00);
  endtask
  // High byte first, as the pairing wants
  task automatic rd16(input logic [7:0] i);
    apb(1'b0, i, 8'h00);
    v[15:8] = rd[7:0];
    apb(1'b0, i + 8'h01, 8'h00);
    v[7:0] = rd[7:0];
  endtask
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    compares++;
    if (s !== e) begin
      $display("[FAIL] %0t got %h want %h", $time, s, e);
      err_total++;
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Run is under a thousand cycles; this leaves wide margin
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Counter leaves reset four counts short of the wrap
    apb(1'b0, `TCS_IDX_CTRL, 8'h00);
    chk(rd, 32'h0);
    apb(1'b1, `TCS_IDX_CMP2H, 8'h80);
    apb(1'b1, `TCS_IDX_CMP2L, 8'h00);
    // The wrap lands sixteen clocks after reset; let it pass first
    repeat (16) @(negedge pclk);
    st();
    chk(rd[5], 1'b1);
    apb(1'b1, `TCS_IDX_CTRL, 8'h20);
    chk(irq, 1'b1);
    apb(1'b0, `TCS_IDX_ALTL, 8'h00);
    st();
    chk(rd[5], 1'b1);
    apb(1'b0, `TCS_IDX_CNTL, 8'h00);
    st();
    chk({rd[5], irq}, 2'h0);
    $display("test overflow done");
    // Match twenty counts ahead, pin driven low first
    apb(1'b1, `TCS_IDX_CTRL, 8'h08);
    rd16(`TCS_IDX_CNTH);
    c0 = v + 16'h0014;
    apb(1'b1, `TCS_IDX_CMP1H, c0[15:8]);
    apb(1'b1, `TCS_IDX_CMP1L, c0[7:0]);
    apb(1'b1, `TCS_IDX_CTRL, 8'h41);
    chk(cmp_one, 1'b0);
    repeat (100) @(negedge pclk);
    st();
    chk({rd[6], cmp_one, irq}, 3'h7);
    apb(1'b1, `TCS_IDX_CMP1L, c0[7:0]);
    st();
    chk({rd[6], irq}, 2'h0);
    $display("test compare done");
    apb(1'b1, `TCS_IDX_CTRL, 8'h1D);
    apb(1'b0, `TCS_IDX_CTRL, 8'h00);
    chk({rd[7:0], cmp_two, cmp_one}, 10'h017);
    apb(1'b1, `TCS_IDX_CTRL, 8'h02);
    st();
    chk({rd[6], rd[3], cmp_two, cmp_one}, 4'h3);
    $display("test force done");
    rd16(`TCS_IDX_CNTH);
    c0 = v;
    tcs_pins_inst.drive(1'b0, 1'b1);
    repeat (8) @(negedge pclk);
    rd16(`TCS_IDX_CNTH);
    c1 = v;
    st();
    chk(rd[7], 1'b1);
    rd16(`TCS_IDX_CAP1H);
    chk(v > c0 && v <= c1 + 16'h0001, 1'b1);
    st();
    chk(rd[7], 1'b0);
    tcs_pins_inst.drive(1'b0, 1'b0);
    repeat (8) @(negedge pclk);
    st();
    chk(rd[7], 1'b0);
    c0 = v;
    apb(1'b0, `TCS_IDX_CAP1H, 8'h00);
    tcs_pins_inst.drive(1'b0, 1'b1);
    repeat (8) @(negedge pclk);
    apb(1'b0, `TCS_IDX_CAP1L, 8'h00);
    chk(rd[7:0], c0[7:0]);
    apb(1'b1, `TCS_IDX_CTRL, 8'h00);
    tcs_pins_inst.drive(1'b0, 1'b0);
    repeat (8) @(negedge pclk);
    rd16(`TCS_IDX_CAP1H);
    chk(v > c0, 1'b1);
    apb(1'b1, `TCS_IDX_CTRL, 8'h80);
    chk(irq, 1'b1);
    $display("test capture one done");
    tcs_pins_inst.drive(1'b1, 1'b0);
    repeat (8) @(negedge pclk);
    st();
    chk(rd[4], 1'b1);
    apb(1'b0, `TCS_IDX_CAP2L, 8'h00);
    tcs_pins_inst.drive(1'b1, 1'b1);
    repeat (8) @(negedge pclk);
    st();
    chk(rd[4], 1'b0);
    apb(1'b0, 8'h3F, 8'h00);
    chk({er, rd}, {1'b1, 32'h0});
    $display("test capture two done");
    conclude();
  end
endmodule // tcs_timer_bench
bind tcs_timer tcs_timer_properties tcs_timer_properties_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .compare_one_pin(compare_one_pin), .compare_two_pin(compare_two_pin),
  .timer_irq(timer_irq));
`default_nettype wire
